/* File: pgd_pkg.sv */
package pgd_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// Host I/O port addresses
	localparam logic [15:0] PORT_PAIR_B   = 16'h03CA;
	localparam logic [15:0] PORT_PAIR_A   = 16'h03CC;
	localparam logic [15:0] PORT_POINTER  = 16'h03CE;
	localparam logic [15:0] PORT_DATA     = 16'h03CF;
	// Indexed register numbers
	localparam logic [7:0] IDX_FILL_VALUE  = 8'h00;
	localparam logic [7:0] IDX_FILL_ENABLE = 8'h01;
	localparam logic [7:0] IDX_CMP_COLOR   = 8'h02;
	localparam logic [7:0] IDX_ROTATE_OP   = 8'h03;
	localparam logic [7:0] IDX_READ_PLANE  = 8'h04;
	localparam logic [7:0] IDX_MODE        = 8'h05;
	localparam logic [7:0] IDX_MISC        = 8'h06;
	localparam logic [7:0] IDX_CMP_MASK    = 8'h07;
	localparam logic [7:0] IDX_BIT_MASK    = 8'h08;
	localparam logic [7:0] IDX_LATCH0      = 8'hF8;
	localparam logic [7:0] IDX_LATCH3      = 8'hFB;
	// Reset values
	localparam logic [7:0] RST_PAIR_A      = 8'h00;
	localparam logic [7:0] RST_PAIR_B      = 8'h01;
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_BIT_MASK    = 8'hFF;
	localparam logic [7:0] RST_CMP_MASK    = 8'h0F;
	// Field positions
	localparam int WMODE_LSB      = 0;
	localparam int RMODE_BIT      = 3;
	localparam int ROT_LSB        = 0;
	localparam int FUNC_LSB       = 3;
	localparam int GFX_BIT        = 0;
	localparam int PTR_HIGH_LSB   = 5;
	localparam int PTR_FLAG_BIT   = 4;
	localparam int PLANES         = 4;

	typedef enum logic [1:0]
	{
		PGD_WM_FILL  = 2'd0,
		PGD_WM_LATCH = 2'd1,
		PGD_WM_COLOR = 2'd2,
		PGD_WM_BAD   = 2'd3
	} pgd_wmode_t;

	typedef enum logic [1:0]
	{
		PGD_OP_PASS = 2'd0,
		PGD_OP_AND  = 2'd1,
		PGD_OP_OR   = 2'd2,
		PGD_OP_XOR  = 2'd3
	} pgd_op_t;

	// Fetch sequencer, one-hot
	typedef enum logic [3:0]
	{
		PGD_F_IDLE  = 4'b0001,
		PGD_F_CHAR  = 4'b0010,
		PGD_F_FONT  = 4'b0100,
		PGD_F_SHIFT = 4'b1000
	} pgd_fstate_t;

	// Four plane bytes travel together
	typedef struct packed
	{
		logic [7:0] p3;
		logic [7:0] p2;
		logic [7:0] p1;
		logic [7:0] p0;
	} pgd_word_t;

	// Host I/O request
	typedef struct packed
	{
		logic        ioWr;
		logic        ioRd;
		logic [15:0] ioAddr;
		logic [7:0]  wrData;
	} pgd_io_t;
endpackage : pgd_pkg

/* File: pgd_datapath.sv */
// Summary of operation
// - Host writes index to pointer port, then data port reaches indexed register.
// - One data port: indices 00-08 are mode registers, F8-FB read latches.
// - The low four pointer bits choose the data-port register; the latch bank also needs upper nibble F.
// - Pointer reads return bits 5, 6, 7 as ones.
// - Pointer bit 4 reads one only if last write set bits 5-7.
// - Pair A steering picks bus bits for planes 0 and 1.
// - Pair B steering picks bus bits for planes 2 and 3.
// - Write mode 0: enabled planes get fill bit on all eight bits.
// - Write mode 0: enabled plane data comes from fill value.
// - Write mode 0: disabled plane data comes from processed CPU byte.
// - Read mode 1: per bit compare planes to color under mask, one on match.
// - Datapath split: section A serves planes 0-1, section B planes 2-3.
// - One CPU write updates all four planes as a 32-bit word.
// - Graphics mode: fetch eight 4-bit pixels, send one per cycle.
// - Text mode: fetch code and attribute, then font byte, forward both.
// - Registers are readable as well as writable; latches are read-only.
// - Mode bits 1:0 choose write mode; 0 is rotate/fill, 3 illegal.
// - Mode bit 3 chooses read mode: plane select or color compare.
// - Compare mask bit 0 excludes a color bit, 1 includes it.
// - Every CPU memory read loads the four plane latches.
module pgd_datapath
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Host I/O bus
	input  wire pgd_pkg::pgd_io_t  io,
	output logic [7:0]             ioRdData,
	// Host memory access
	input  wire logic              memWr,
	input  wire logic              memRd,
	input  wire logic [7:0]        memWrData,
	output logic [7:0]             memRdData,
	// Display planes
	input  wire pgd_pkg::pgd_word_t planeRdWord,
	output pgd_pkg::pgd_word_t     planeWrWord,
	output logic [3:0]             planeWrEn,
	// Display fetch
	input  wire logic              fetchStart,
	input  wire pgd_pkg::pgd_word_t fetchWord,
	input  wire logic [7:0]        fontByte,
	output logic                   fontReq,
	output logic [3:0]             pixelOut,
	output logic                   pixelValid,
	output logic [7:0]             textFont,
	output logic [7:0]             textAttr,
	output logic                   textValid
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////
	logic [7:0] pointer, next_pointer;
	logic       ptrFlag, next_ptrFlag;
	logic [7:0] pairA, next_pairA, pairB, next_pairB;
	logic [7:0] regs [0:8];
	logic [7:0] next_regs [0:8];
	pgd_pkg::pgd_word_t latches, next_latches;
	logic [7:0] ioRdNext, memRdNext;
	logic [3:0] idx;
	logic       latchSel;
	logic [7:0] fillValue, fillEnable, cmpColor, rotOp, readSel, modeReg, miscReg;
	logic [7:0] cmpMask, bitMask;

	assign idx        = pointer[3:0];
	// Only the latch bank looks at the upper nibble, since 08 and F8 share a low nibble
	assign latchSel   = pointer[7:4] == pgd_pkg::IDX_LATCH0[7:4]
		&& idx >= pgd_pkg::IDX_LATCH0[3:0] && idx <= pgd_pkg::IDX_LATCH3[3:0];
	assign fillValue  = regs[0];
	assign fillEnable = regs[1];
	assign cmpColor   = regs[2];
	assign rotOp      = regs[3];
	assign readSel    = regs[4];
	assign modeReg    = regs[5];
	assign miscReg    = regs[6];
	assign cmpMask    = regs[7];
	assign bitMask    = regs[8];

	////////////////////////////////////////////////////////////////////////////
	// Register file and host reads
	always_comb
	begin
		next_pointer = pointer;
		next_ptrFlag = ptrFlag;
		next_pairA   = pairA;
		next_pairB   = pairB;
		for (int i = 0; i < 9; i++)
			next_regs[i] = regs[i];
		ioRdNext = ioRdData;
		if (io.ioWr)
		begin
			unique case (io.ioAddr)
				pgd_pkg::PORT_POINTER:
				begin
					next_pointer = io.wrData;
					next_ptrFlag = &io.wrData[7:pgd_pkg::PTR_HIGH_LSB];
				end
				pgd_pkg::PORT_PAIR_A: next_pairA = io.wrData;
				pgd_pkg::PORT_PAIR_B: next_pairB = io.wrData;
				pgd_pkg::PORT_DATA:
					// Latch indices are read-only; writes there are dropped
					if (!latchSel && idx <= pgd_pkg::IDX_BIT_MASK[3:0])
						next_regs[idx] = io.wrData;
				default: ;
			endcase
		end
		if (io.ioRd)
		begin
			unique case (io.ioAddr)
				pgd_pkg::PORT_POINTER:
					ioRdNext = {3'b111, ptrFlag, pointer[3:0]};
				pgd_pkg::PORT_PAIR_A: ioRdNext = pairA;
				pgd_pkg::PORT_PAIR_B: ioRdNext = pairB;
				pgd_pkg::PORT_DATA:
				begin
					if (latchSel)
						ioRdNext = latches[(32'(idx) - 8) * 8 +: 8];
					else if (idx <= pgd_pkg::IDX_BIT_MASK[3:0])
						ioRdNext = regs[idx];
					else
						ioRdNext = 8'h00;
				end
				default: ioRdNext = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pointer  <= pgd_pkg::RST_ZERO;
			ptrFlag  <= 1'b0;
			pairA    <= pgd_pkg::RST_PAIR_A;
			pairB    <= pgd_pkg::RST_PAIR_B;
			ioRdData <= pgd_pkg::RST_ZERO;
			for (int i = 0; i < 9; i++)
				regs[i] <= pgd_pkg::RST_ZERO;
			regs[7]  <= pgd_pkg::RST_CMP_MASK;
			regs[8]  <= pgd_pkg::RST_BIT_MASK;
		end
		else
		begin
			pointer  <= next_pointer;
			ptrFlag  <= next_ptrFlag;
			pairA    <= next_pairA;
			pairB    <= next_pairB;
			ioRdData <= ioRdNext;
			for (int i = 0; i < 9; i++)
				regs[i] <= next_regs[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus bit steering: a pair register names which bus bit pair feeds a plane pair
	function automatic logic [1:0] pairSel(input logic [7:0] bus, input logic [7:0] pos);
		pairSel = bus[2 * 32'(pos[1:0]) +: 2];
	endfunction : pairSel

	logic [3:0] steered;
	assign steered = {pairSel(memWrData, pairB), pairSel(memWrData, pairA)};

	////////////////////////////////////////////////////////////////////////////
	// CPU write path
	logic [7:0]          rotated;
	pgd_pkg::pgd_word_t  wrWord;
	pgd_pkg::pgd_wmode_t wmode;
	pgd_pkg::pgd_op_t    op;
	logic [2:0]          rot;

	assign wmode = pgd_pkg::pgd_wmode_t'(modeReg[pgd_pkg::WMODE_LSB +: 2]);
	assign op    = pgd_pkg::pgd_op_t'(rotOp[pgd_pkg::FUNC_LSB +: 2]);
	assign rot   = rotOp[pgd_pkg::ROT_LSB +: 3];
	assign rotated = 8'(({memWrData, memWrData} >> rot));

	always_comb
	begin
		logic [7:0] src;
		logic [7:0] lat;
		src = 8'h00;
		lat = 8'h00;
		wrWord = latches;
		for (int p = 0; p < pgd_pkg::PLANES; p++)
		begin
			lat = latches[p * 8 +: 8];
			unique case (wmode)
				pgd_pkg::PGD_WM_FILL:
					src = fillEnable[p] ? {8{fillValue[p]}} : rotated;
				pgd_pkg::PGD_WM_LATCH: src = lat;
				pgd_pkg::PGD_WM_COLOR: src = {8{steered[p]}};
				pgd_pkg::PGD_WM_BAD:   src = lat;
			endcase
			if (wmode != pgd_pkg::PGD_WM_LATCH)
			begin
				unique case (op)
					pgd_pkg::PGD_OP_PASS: src = src;
					pgd_pkg::PGD_OP_AND:  src = src & lat;
					pgd_pkg::PGD_OP_OR:   src = src | lat;
					pgd_pkg::PGD_OP_XOR:  src = src ^ lat;
				endcase
				src = (src & bitMask) | (lat & ~bitMask);
			end
			wrWord[p * 8 +: 8] = src;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// CPU read path and latches
	logic [7:0] match;
	always_comb
	begin
		for (int b = 0; b < 8; b++)
			match[b] = &(~({planeRdWord.p3[b], planeRdWord.p2[b],
				planeRdWord.p1[b], planeRdWord.p0[b]} ^ cmpColor[3:0]) | ~cmpMask[3:0]);
		next_latches = memRd ? planeRdWord : latches;
		memRdNext = memRdData;
		if (memRd)
		begin
			if (modeReg[pgd_pkg::RMODE_BIT])
				memRdNext = match;
			else
				memRdNext = planeRdWord[32'(readSel[1:0]) * 8 +: 8];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			latches     <= '0;
			memRdData   <= pgd_pkg::RST_ZERO;
			planeWrWord <= '0;
			planeWrEn   <= 4'h0;
		end
		else
		begin
			latches     <= next_latches;
			memRdData   <= memRdNext;
			planeWrWord <= wrWord;
			// Illegal write mode leaves memory untouched
			planeWrEn   <= {4{memWr && wmode != pgd_pkg::PGD_WM_BAD}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Display fetch toward the attribute stage
	pgd_pkg::pgd_fstate_t fState, next_fState;
	pgd_pkg::pgd_word_t   shiftWord, next_shiftWord;
	logic [2:0]           pixCnt, next_pixCnt;
	logic [7:0]           attrHold, next_attrHold;
	logic [3:0]           next_pixelOut;
	logic                 next_pixelValid, next_fontReq, next_textValid;
	logic [7:0]           next_textFont, next_textAttr;

	always_comb
	begin
		next_fState     = fState;
		next_shiftWord  = shiftWord;
		next_pixCnt     = pixCnt;
		next_attrHold   = attrHold;
		next_pixelOut   = pixelOut;
		next_pixelValid = 1'b0;
		next_fontReq    = 1'b0;
		next_textValid  = 1'b0;
		next_textFont   = textFont;
		next_textAttr   = textAttr;
		unique case (fState)
			pgd_pkg::PGD_F_IDLE:
				if (fetchStart)
				begin
					if (miscReg[pgd_pkg::GFX_BIT])
					begin
						next_shiftWord = fetchWord;
						next_pixCnt    = 3'd0;
						next_fState    = pgd_pkg::PGD_F_SHIFT;
					end
					else
					begin
						// Plane 1 carries the attribute beside the code in plane 0
						next_attrHold = fetchWord.p1;
						next_fontReq  = 1'b1;
						next_fState   = pgd_pkg::PGD_F_CHAR;
					end
				end
			pgd_pkg::PGD_F_CHAR:
				next_fState = pgd_pkg::PGD_F_FONT;
			pgd_pkg::PGD_F_FONT:
			begin
				next_textFont  = fontByte;
				next_textAttr  = attrHold;
				next_textValid = 1'b1;
				next_fState    = pgd_pkg::PGD_F_IDLE;
			end
			pgd_pkg::PGD_F_SHIFT:
			begin
				// Most significant bit leaves first
				next_pixelOut   = {shiftWord.p3[7], shiftWord.p2[7],
					shiftWord.p1[7], shiftWord.p0[7]};
				next_pixelValid = 1'b1;
				next_shiftWord  = {shiftWord.p3 << 1, shiftWord.p2 << 1,
					shiftWord.p1 << 1, shiftWord.p0 << 1};
				next_pixCnt     = pixCnt + 3'd1;
				if (pixCnt == 3'd7)
					next_fState = pgd_pkg::PGD_F_IDLE;
			end
			default: next_fState = pgd_pkg::PGD_F_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fState     <= pgd_pkg::PGD_F_IDLE;
			shiftWord  <= '0;
			pixCnt     <= 3'd0;
			attrHold   <= 8'h00;
			pixelOut   <= 4'h0;
			pixelValid <= 1'b0;
			fontReq    <= 1'b0;
			textValid  <= 1'b0;
			textFont   <= 8'h00;
			textAttr   <= 8'h00;
		end
		else
		begin
			fState     <= next_fState;
			shiftWord  <= next_shiftWord;
			pixCnt     <= next_pixCnt;
			attrHold   <= next_attrHold;
			pixelOut   <= next_pixelOut;
			pixelValid <= next_pixelValid;
			fontReq    <= next_fontReq;
			textValid  <= next_textValid;
			textFont   <= next_textFont;
			textAttr   <= next_textAttr;
		end
	end
endmodule : pgd_datapath

/* File: pgd_props.sv */
module pgd_props
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst_b,
	// Watched ports
	input wire pgd_pkg::pgd_io_t io,
	input wire logic [7:0]       ioRdData,
	input wire logic             memWr,
	input wire logic [3:0]       planeWrEn,
	input wire logic             fetchStart,
	input wire logic             fontReq,
	input wire logic             pixelValid,
	input wire logic             textValid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic ptrRd;
	logic highSet;
	// Tracks the last pointer write so the flag bit has something to be judged against
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ptrRd   <= 1'b0;
			highSet <= 1'b0;
		end
		else
		begin
			ptrRd <= io.ioRd && io.ioAddr == pgd_pkg::PORT_POINTER;
			if (io.ioWr && io.ioAddr == pgd_pkg::PORT_POINTER)
				highSet <= &io.wrData[7:5];
		end
	end
	//////////////////////////////////////////
	a_wr_all_planes: assert property (planeWrEn != 4'h0 |-> planeWrEn == 4'hF)
		else $error("partial plane write");
	a_wr_has_cause: assert property (planeWrEn != 4'h0 |-> $past(memWr))
		else $error("plane write without host write");
	a_font_after_start: assert property (fontReq |-> $past(fetchStart))
		else $error("font request without fetch start");
	a_text_after_font: assert property (textValid |-> $past(fontReq, 2))
		else $error("text output without font request");
	a_pixel_burst: assert property ($rose(pixelValid) |-> pixelValid[*8] ##1 !pixelValid)
		else $error("pixel burst not eight long");
	a_pixel_cause: assert property ($rose(pixelValid) |-> $past(fetchStart, 2))
		else $error("pixels without fetch start");
	a_pointer_ones: assert property (ptrRd |-> ioRdData[7:5] == 3'b111)
		else $error("pointer high bits not ones");
	a_pointer_flag: assert property (ptrRd |-> ioRdData[4] == highSet)
		else $error("pointer flag bit wrong");
	a_rd_data_holds: assert property (!$past(io.ioRd) |-> $stable(ioRdData))
		else $error("read data changed without read");
	c_burst: cover property ($rose(pixelValid));
	c_text: cover property (textValid);
	c_write: cover property (planeWrEn == 4'hF);
endmodule : pgd_props

/* File: pgd_host.sv */
module pgd_host
(
	// Clock
	input wire logic       clk,
	// Requests
	output pgd_pkg::pgd_io_t io,
	output logic           memWr,
	output logic           memRd,
	output logic [7:0]     memWrData,
	// Answers
	input wire logic [7:0] ioRdData,
	input wire logic [7:0] memRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		io        = '0;
		memWr     = 1'b0;
		memRd     = 1'b0;
		memWrData = 8'h00;
	end
	// Released lines are inverted so stale values never look valid
	task automatic ioAccess(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		@(posedge clk);
		#1;
		io = '{ioWr: wr, ioRd: !wr, ioAddr: a, wrData: d};
		@(posedge clk);
		#1;
		rd = ioRdData;
		io = '{ioWr: 1'b0, ioRd: 1'b0, ioAddr: ~a, wrData: ~d};
	endtask : ioAccess
	task automatic memAccess(input logic wr, input logic [7:0] d, output logic [7:0] rd);
		@(posedge clk);
		#1;
		memWr     = wr;
		memRd     = !wr;
		memWrData = d;
		@(posedge clk);
		#1;
		rd        = memRdData;
		memWr     = 1'b0;
		memRd     = 1'b0;
		memWrData = ~d;
	endtask : memAccess
endmodule : pgd_host

/* File: planar_graphics_datapath_test.sv */
module planar_graphics_datapath_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	pgd_pkg::pgd_io_t  io;
	pgd_pkg::pgd_word_t planeRdWord = '0, planeWrWord, fetchWord = '0;
	logic [7:0]        ioRdData, memWrData, memRdData, textFont, textAttr, rd;
	logic [7:0]        fontByte = 8'h00;
	logic [3:0]        planeWrEn, pixelOut;
	logic              memWr, memRd, fontReq, pixelValid, textValid;
	logic              fetchStart = 1'b0;
	logic              fontSeen = 1'b0;
	int                fails = 0;
	int                cmpCount = 0;
	always #10 clk = ~clk;
	pgd_datapath i_dut (.clk(clk), .rst_b(rst_b), .io(io), .ioRdData(ioRdData),
		.memWr(memWr), .memRd(memRd), .memWrData(memWrData), .memRdData(memRdData),
		.planeRdWord(planeRdWord), .planeWrWord(planeWrWord), .planeWrEn(planeWrEn),
		.fetchStart(fetchStart), .fetchWord(fetchWord), .fontByte(fontByte),
		.fontReq(fontReq), .pixelOut(pixelOut), .pixelValid(pixelValid),
		.textFont(textFont), .textAttr(textAttr), .textValid(textValid));
	pgd_host i_host (.clk(clk), .io(io), .memWr(memWr), .memRd(memRd),
		.memWrData(memWrData), .ioRdData(ioRdData), .memRdData(memRdData));
	//////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic setReg(input logic [7:0] idx, input logic [7:0] val);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_POINTER, idx, rd);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_DATA, val, rd);
	endtask : setReg
	task automatic getReg(input logic [7:0] idx);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_POINTER, idx, rd);
		i_host.ioAccess(1'b0, pgd_pkg::PORT_DATA, 8'h00, rd);
	endtask : getReg
	task automatic pulseStart;
		int n;
		@(posedge clk);
		#1;
		fetchStart = 1'b1;
		@(posedge clk);
		#1;
		fetchStart = 1'b0;
		fontSeen = fontReq;
		n = 0;
		// Bounded so a silent fetch engine cannot hang the run
		while (pixelValid !== 1'b1 && textValid !== 1'b1 && n < 12)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : pulseStart
	//////////////////////////////////////////
	task automatic testResetAndPointer;
		i_host.ioAccess(1'b0, pgd_pkg::PORT_PAIR_A, 8'h00, rd);
		check(rd, 8'h00);
		i_host.ioAccess(1'b0, pgd_pkg::PORT_PAIR_B, 8'h00, rd);
		check(rd, 8'h01);
		getReg(8'h07);
		check(rd, 8'h0F);
		getReg(8'h08);
		check(rd, 8'hFF);
		getReg(8'h27);
		check(rd, 8'h0F);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_POINTER, 8'hE5, rd);
		i_host.ioAccess(1'b0, pgd_pkg::PORT_POINTER, 8'h00, rd);
		check(rd, 8'hF5);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_POINTER, 8'h45, rd);
		i_host.ioAccess(1'b0, pgd_pkg::PORT_POINTER, 8'h00, rd);
		check(rd, 8'hE5);
	endtask : testResetAndPointer
	task automatic testFill;
		setReg(8'h05, 8'h00);
		setReg(8'h00, 8'h05);
		setReg(8'h01, 8'h0F);
		i_host.memAccess(1'b1, 8'hAA, rd);
		check(planeWrWord, 32'h00FF_00FF);
		check(planeWrEn, 4'hF);
		setReg(8'h01, 8'h03);
		i_host.memAccess(1'b1, 8'hAA, rd);
		check(planeWrWord, 32'hAAAA_00FF);
		setReg(8'h05, 8'h03);
		i_host.memAccess(1'b1, 8'hFF, rd);
		check(planeWrEn, 4'h0);
	endtask : testFill
	task automatic testCompare;
		planeRdWord = 32'h00FE_01FF;
		setReg(8'h05, 8'h08);
		setReg(8'h02, 8'h03);
		i_host.memAccess(1'b0, 8'h00, rd);
		check(rd, 8'h01);
		setReg(8'h07, 8'h01);
		i_host.memAccess(1'b0, 8'h00, rd);
		check(rd, 8'hFF);
		getReg(8'hF8);
		check(rd, 8'hFF);
		getReg(8'hFB);
		check(rd, 8'h00);
		getReg(8'hFA);
		check(rd, 8'hFE);
		setReg(8'h05, 8'h00);
		setReg(8'h04, 8'h02);
		i_host.memAccess(1'b0, 8'h00, rd);
		check(rd, 8'hFE);
	endtask : testCompare
	task automatic testSteering;
		setReg(8'h05, 8'h02);
		i_host.memAccess(1'b1, 8'h04, rd);
		check(planeWrWord, 32'h00FF_0000);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_PAIR_A, 8'h01, rd);
		i_host.memAccess(1'b1, 8'h04, rd);
		check(planeWrWord, 32'h00FF_00FF);
		i_host.ioAccess(1'b1, pgd_pkg::PORT_PAIR_B, 8'h00, rd);
		i_host.memAccess(1'b1, 8'h04, rd);
		check(planeWrWord, 32'h0000_00FF);
	endtask : testSteering
	// Latches still hold the last read word from the compare scenario
	task automatic testLogic;
		setReg(8'h05, 8'h01);
		i_host.memAccess(1'b1, 8'h55, rd);
		check(planeWrWord, 32'h00FE_01FF);
		setReg(8'h05, 8'h00);
		setReg(8'h01, 8'h00);
		setReg(8'h03, 8'h1A);
		setReg(8'h08, 8'hF0);
		i_host.memAccess(1'b1, 8'h0F, rd);
		check(planeWrWord, 32'hC03E_C13F);
		setReg(8'h03, 8'h00);
		setReg(8'h08, 8'hFF);
	endtask : testLogic
	task automatic testFetch;
		setReg(8'h06, 8'h01);
		fetchWord = 32'h01FF_0080;
		pulseStart();
		for (int i = 7; i >= 0; i--)
		begin
			check({pixelValid, pixelOut}, {1'b1, fetchWord.p3[i], fetchWord.p2[i],
				fetchWord.p1[i], fetchWord.p0[i]});
			@(posedge clk);
			#1;
		end
		check(pixelValid, 1'b0);
		check(fontSeen, 1'b0);
		setReg(8'h06, 8'h00);
		fetchWord = 32'h0000_1E41;
		fontByte  = 8'h3C;
		pulseStart();
		check({textValid, textFont, textAttr}, {1'b1, 16'h3C1E});
		check(fontSeen, 1'b1);
	endtask : testFetch
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		testResetAndPointer();
		testFill();
		testCompare();
		testSteering();
		testLogic();
		testFetch();
		complete_run();
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		#100us;
		fails++;
		complete_run();
	end
endmodule : planar_graphics_datapath_test
bind pgd_datapath pgd_props i_props (.clk(clk), .rst_b(rst_b), .io(io), .ioRdData(ioRdData),
	.memWr(memWr), .planeWrEn(planeWrEn), .fetchStart(fetchStart), .fontReq(fontReq),
	.pixelValid(pixelValid), .textValid(textValid));
